/* File: hw/flash_program_control.sv */
// Flash program control: control register, launch supervision, bank swap.
// Assumes rst_n is the power-on reset and the flash engine is on clk_sys.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module flash_program_control
	import flash_ctrl_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         sysRst_n,
	input  wire logic [7:0]   regAddr,
	input  wire logic [31:0]  regWdata,
	input  wire logic         regWr,
	input  wire logic         regRd,
	output logic      [31:0]  regRdata,
	input  wire logic         unlockDone,
	input  wire logic         opDone,
	input  wire logic         opFail,
	input  wire logic         lowVoltPin,
	output logic              opStart,
	output logic      [3:0]   opCode,
	output logic              bankSwap,
	output logic              lowerBank2,
	output logic              irq
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic        launch_q;
	logic        launch_d;
	logic        arm_q;
	logic        arm_d;
	logic        seqFail_q;
	logic        seqFail_d;
	logic        lowVolt_q;
	logic        lowVolt_d;
	logic        swap_q;
	logic        swap_d;
	logic [3:0]  opSel_q;
	logic [3:0]  opSel_d;
	logic        unlock_q;
	logic        unlock_d;
	seq_state_t  state_q;
	seq_state_t  state_d;
	logic        opStart_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        swapOut_q;
	logic        lowerBank2_q;

	logic        lowVoltSync;
	logic        sysRstSync;
	logic        softReset;

	logic        ctrlWr;
	logic        irqClrWr;
	logic        irqEnWr;
	logic        ctrlRd;
	logic        statRd;
	logic        enRd;
	logic        launchReq;
	logic        launchOk;
	logic        clearLaunch;
	logic        swapReq;
	logic        swapOk;
	logic        opEnd;
	logic        opEndFail;
	logic        lowVoltEvt;
	logic [31:0] ctrlValue;
	logic        wrLaunch;
	logic        wrArm;
	logic        wrSwap;
	logic [3:0]  wrOpSel;
	logic        opSelWr;
	logic        seqIdle;
	logic        seqBusy;
	logic        opStart_d;
	logic [31:0] statValue;
	logic [31:0] enValue;

	logic [IRQ_W-1:0] irqEvents;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqEnable;
	logic             irqLine;
	logic [IRQ_W-1:0] irqClrMask;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	sync_2ff #(
		.W (2)
	) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.asyncIn ({lowVoltPin, ~sysRst_n}),
		.syncOut ({lowVoltSync, sysRstSync})
	);

	// Non-POR reset: clears select, swap and interrupt state only
	// Carried active high so the synchroniser's reset value is idle
	assign softReset = sysRstSync;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	assign ctrlWr   = regWr && (regAddr == CTRL_OFFSET);
	assign irqClrWr = regWr && (regAddr == IRQ_CLR_OFFSET);
	assign irqEnWr  = regWr && (regAddr == IRQ_EN_OFFSET);
	assign ctrlRd   = regRd && (regAddr == CTRL_OFFSET);
	assign statRd   = regRd && (regAddr == IRQ_STAT_OFFSET);
	assign enRd     = regRd && (regAddr == IRQ_EN_OFFSET);

	// ****************************************************************
	// Write data fields
	// ****************************************************************
	assign wrLaunch = regWdata[LAUNCH_BIT];
	assign wrArm    = regWdata[ARM_BIT];
	assign wrSwap   = regWdata[SWAP_BIT];
	assign wrOpSel  = regWdata[OPSEL_LSB +: OPSEL_W];
	assign opSelWr  = ctrlWr && !arm_q;

	// ****************************************************************
	// Control write qualification
	// ****************************************************************
	// Launch needs arm already set and a fresh unlock
	assign launchReq = ctrlWr && wrLaunch;
	assign launchOk  = launchReq && arm_q && unlock_q && !launch_q && seqIdle;

	// Swap change needs arm clear and a fresh unlock
	assign swapReq = ctrlWr && (wrSwap != swap_q);
	assign swapOk  = swapReq && !arm_q && unlock_q;

	// Launch with select zero is a flag clear with no flash activity
	assign clearLaunch = launchOk && (opSel_q == OPSEL_CLEAR);

	assign seqIdle    = (state_q == SEQ_IDLE);
	assign seqBusy    = (state_q == SEQ_BUSY);
	assign opEnd      = seqBusy && opDone;
	assign opEndFail  = opEnd && opFail;
	assign lowVoltEvt = lowVoltSync && !lowVolt_q;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	// Unlock is consumed by the write it enables
	assign unlock_d = unlockDone ? 1'b1 :
	                  ((launchOk || swapOk) ? 1'b0 : unlock_q);

	assign arm_d = ctrlWr ? wrArm : arm_q;

	// Software writes of zero have no effect on launch
	assign launch_d = (launchOk && !clearLaunch) ? 1'b1 :
	                  (opEnd ? 1'b0 : launch_q);

	assign opSel_d = softReset ? OPSEL_RESET :
	                 (opSelWr ?
	                  wrOpSel : opSel_q);

	assign swap_d = softReset ? 1'b0 :
	                (swapOk ? wrSwap : swap_q);

	// Set wins over the clearing launch
	assign seqFail_d = (opEndFail || (launch_q && lowVoltSync)) ? 1'b1 :
	                   (clearLaunch ? 1'b0 : seqFail_q);

	assign lowVolt_d = lowVoltSync ? 1'b1 :
	                   (clearLaunch ? 1'b0 : lowVolt_q);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SEQ_IDLE: begin
				if (launchOk && !clearLaunch) begin
					state_d = SEQ_START;
				end
			end
			SEQ_START: begin
				state_d = SEQ_BUSY;
			end
			SEQ_BUSY: begin
				if (opDone) begin
					state_d = SEQ_IDLE;
				end
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Power-on-only state
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			launch_q <= 1'b0;
			arm_q    <= 1'b0;
		end else begin
			launch_q <= launch_d;
			arm_q    <= arm_d;
		end
	end

	// ****************************************************************
	// Error flags
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seqFail_q <= 1'b0;
			lowVolt_q <= 1'b0;
		end else begin
			seqFail_q <= seqFail_d;
			lowVolt_q <= lowVolt_d;
		end
	end

	// ****************************************************************
	// Unlock pending
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			unlock_q <= 1'b0;
		end else begin
			unlock_q <= unlock_d;
		end
	end

	// ****************************************************************
	// Sequencer register
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SEQ_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************************************
	// Configuration state
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			opSel_q <= OPSEL_RESET;
			swap_q  <= 1'b0;
		end else begin
			opSel_q <= opSel_d;
			swap_q  <= swap_d;
		end
	end

	// ****************************************************************
	// Interrupt status
	// ****************************************************************
	assign irqEvents  = {lowVoltEvt, opEndFail, opEnd || clearLaunch};
	assign irqClrMask = irqClrWr ? regWdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

	irq_sticky #(
		.W (IRQ_W)
	) u_irq (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.softClr  (softReset),
		.eventIn  (irqEvents),
		.clrIn    (irqClrMask),
		.enWr     (irqEnWr),
		.enData   (regWdata[IRQ_W-1:0]),
		.status_q (irqStatus),
		.enable_q (irqEnable),
		.irq_q    (irqLine)
	);

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Upper half is unimplemented
	assign ctrlValue = {16'h0000, launch_q, arm_q, seqFail_q, lowVolt_q,
	                    4'h0, swap_q, 3'h0, opSel_q};

	assign statValue = {29'h0000000, irqStatus};
	assign enValue   = {29'h0000000, irqEnable};

	assign rdata_d = ctrlRd ? ctrlValue :
	                 statRd ? statValue :
	                 enRd   ? enValue :
	                 32'h00000000;

	// ****************************************************************
	// Output registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ****************************************************************
	// Start pulse
	// ****************************************************************
	assign opStart_d = (state_d == SEQ_START);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			opStart_q <= 1'b0;
		end else begin
			opStart_q <= opStart_d;
		end
	end

	// ****************************************************************
	// Bank mapping
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			swapOut_q    <= 1'b0;
			lowerBank2_q <= 1'b0;
		end else begin
			swapOut_q    <= swap_d;
			lowerBank2_q <= swap_d;
		end
	end

	assign regRdata   = rdata_q;
	assign opStart    = opStart_q;
	assign opCode     = opSel_q;
	assign bankSwap   = swapOut_q;
	assign lowerBank2 = lowerBank2_q;
	assign irq        = irqLine;

endmodule // flash_program_control

/* File: hw/flash_ctrl_pkg.sv */
// Constants for the flash program control block.
// Assumes a 200 MHz system clock and a 32-bit register port.
package flash_ctrl_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
	localparam logic [7:0]  IRQ_STAT_OFFSET = 8'h04;
	localparam logic [7:0]  IRQ_CLR_OFFSET  = 8'h08;
	localparam logic [7:0]  IRQ_EN_OFFSET   = 8'h0C;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int          LAUNCH_BIT      = 15;
	localparam int          ARM_BIT         = 14;
	localparam int          SEQ_FAIL_BIT    = 13;
	localparam int          LOW_VOLT_BIT    = 12;
	localparam int          SWAP_BIT        = 7;
	localparam int          OPSEL_LSB       = 0;
	localparam int          OPSEL_W         = 4;
	localparam logic [3:0]  OPSEL_CLEAR     = 4'h0;
	localparam logic [3:0]  OPSEL_RESET     = 4'h0;

	// ****************************************************************
	// Interrupt status layout
	// ****************************************************************
	localparam int          IRQ_W           = 3;
	localparam int          IRQ_DONE_BIT    = 0;
	localparam int          IRQ_FAIL_BIT    = 1;
	localparam int          IRQ_LOWV_BIT    = 2;
	localparam logic [2:0]  IRQ_EN_RESET    = 3'h0;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_START = 2'b01,
		SEQ_BUSY  = 2'b10
	} seq_state_t;

endpackage

/* File: hw/sync_2ff.sv */
// Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes inputs are quasi-static relative to clk_sys.
`timescale 1ns/100ps
module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule // sync_2ff

/* File: hw/irq_sticky.sv */
// Sticky event status with write-one-to-clear, enable mask and level irq.
// Assumes events and clears come from logic on clk_sys.
`timescale 1ns/100ps
module irq_sticky #(
	parameter int W = 3
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         softClr,
	input  wire logic [W-1:0] eventIn,
	input  wire logic [W-1:0] clrIn,
	input  wire logic         enWr,
	input  wire logic [W-1:0] enData,
	output logic      [W-1:0] status_q,
	output logic      [W-1:0] enable_q,
	output logic              irq_q
);
	logic [W-1:0] status_d;
	logic [W-1:0] enable_d;

	// Set wins over clear
	assign status_d = softClr ? eventIn : ((status_q & ~clrIn) | eventIn);
	assign enable_d = softClr ? '0 : (enWr ? enData : enable_q);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= '0;
			enable_q <= '0;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			enable_q <= enable_d;
			irq_q    <= |(status_d & enable_d);
		end
	end
endmodule // irq_sticky

/* File: verif/flash_program_control_props.sv */
// Checker: port-level properties of flash_program_control.
// Assumes one clk_sys domain with rst_n as the power-on reset.
`timescale 1ns/100ps
module flash_program_control_props
	import flash_ctrl_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        sysRst_n,
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic        opStart,
	input wire logic [3:0]  opCode,
	input wire logic        bankSwap,
	input wire logic        lowerBank2,
	input wire logic        irq
);
	logic [3:0] sysHist_q;
	wire        sysQuiet = (&sysHist_q) & sysRst_n;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			sysHist_q <= 4'hF;
		else
			sysHist_q <= {sysHist_q[2:0], sysRst_n};
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ****
	// Properties
	// ****
	sequence sOnePulse;
		opStart ##1 !opStart;
	endsequence

	chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data not zero outside read slot");
	chk_unused_zero: assert property ($past(regRd) && $past(regAddr) == CTRL_OFFSET
		|-> (regRdata & 32'hFFFF0F70) == 32'h0)
		else $error("unimplemented control bits not zero");
	chk_bank_map: assert property (lowerBank2 == bankSwap)
		else $error("bank map disagrees with swap bit");
	chk_bank_readback: assert property ($past(regRd) && $past(regAddr) == CTRL_OFFSET
		&& sysQuiet |-> regRdata[SWAP_BIT] == lowerBank2)
		else $error("bank map disagrees with read swap bit");
	chk_op_nonzero: assert property (opStart |-> opCode != OPSEL_CLEAR)
		else $error("start issued for clear-only code");
	chk_start_pulse: assert property (opStart |-> sOnePulse)
		else $error("start pulse longer than one cycle");
	chk_launch_cause: assert property (opStart |-> $past(regWr)
		&& $past(regWdata[LAUNCH_BIT]) && $past(regAddr) == CTRL_OFFSET)
		else $error("start without launch write");
	chk_opsel_write: assert property ($changed(opCode) && sysQuiet
		|-> $past(regWr) || $past(regWr, 2))
		else $error("operation code changed without write");
	chk_swap_write: assert property ($changed(bankSwap) && sysQuiet
		|-> $past(regWr) || $past(regWr, 2))
		else $error("swap changed without write");
	chk_irq_sticky: assert property ($fell(irq) && sysQuiet
		|-> $past(regWr) || $past(regWr, 2))
		else $error("interrupt dropped without write");
endmodule // flash_program_control_props

bind flash_program_control flash_program_control_props chk (.clk_sys(clk_sys),
	.rst_n(rst_n), .sysRst_n(sysRst_n), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .opStart(opStart),
	.opCode(opCode), .bankSwap(bankSwap), .lowerBank2(lowerBank2), .irq(irq));

/* File: verif/flash_program_control_tb.sv */
// Testbench: register-level scenarios for flash_program_control.
// Assumes the package constants and a 200 MHz clk_sys.
`timescale 1ns/100ps
module flash_program_control_tb;
	import flash_ctrl_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        sysRst_n = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic        unlockDone = 1'b0;
	logic        opDone = 1'b0;
	logic        opFail = 1'b0;
	logic        lowVoltPin = 1'b0;
	logic [31:0] regRdata;
	logic [3:0]  opCode;
	logic        opStart, bankSwap, lowerBank2, irq;
	int          bad_count = 0;
	int          n_compared = 0;

	flash_program_control uut (.clk_sys(clk_sys), .rst_n(rst_n), .sysRst_n(sysRst_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .unlockDone(unlockDone), .opDone(opDone), .opFail(opFail),
		.lowVoltPin(lowVoltPin), .opStart(opStart), .opCode(opCode),
		.bankSwap(bankSwap), .lowerBank2(lowerBank2), .irq(irq));

	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ****
	// Bus and check tasks
	// ****
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 check(what, regRdata, exp);
	endtask

	task automatic unlock;
		@(posedge clk_sys);
		unlockDone <= 1'b1;
		@(posedge clk_sys);
		unlockDone <= 1'b0;
	endtask

	task automatic countStarts(output int n);
		n = 0;
		repeat (5) begin
			#1 if (opStart === 1'b1) n++;
			@(posedge clk_sys);
		end
	endtask

	// ****
	// Scenarios
	// ****
	task automatic tArmLaunch;
		int n;
		wr(CTRL_OFFSET, 32'hFFFF0F73);
		rdChk("ctrl", CTRL_OFFSET, 32'h00000003);
		check("opCode", {28'h0, opCode}, 32'h3);
		unlock();
		wr(CTRL_OFFSET, 32'h0000C003);
		rdChk("ctrl", CTRL_OFFSET, 32'h00004003);
		wr(CTRL_OFFSET, 32'h00004005);
		rdChk("ctrl", CTRL_OFFSET, 32'h00004003);
		unlock();
		wr(CTRL_OFFSET, 32'h0000C003);
		countStarts(n);
		check("starts", 32'(n), 32'h1);
		wr(CTRL_OFFSET, 32'h00004003);
		rdChk("ctrl", CTRL_OFFSET, 32'h0000C003);
		@(posedge clk_sys);
		opDone <= 1'b1;
		opFail <= 1'b1;
		@(posedge clk_sys);
		opDone <= 1'b0;
		rdChk("ctrl", CTRL_OFFSET, 32'h00006003);
	endtask

	task automatic tLowVolt;
		int n;
		@(posedge clk_sys);
		lowVoltPin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdChk("ctrl", CTRL_OFFSET, 32'h00007003);
		@(posedge clk_sys);
		lowVoltPin <= 1'b0;
		wr(CTRL_OFFSET, 32'h00000000);
		rdChk("ctrl", CTRL_OFFSET, 32'h00003003);
		wr(CTRL_OFFSET, 32'h00004000);
		unlock();
		wr(CTRL_OFFSET, 32'h0000C000);
		countStarts(n);
		check("starts", 32'(n), 32'h0);
		rdChk("ctrl", CTRL_OFFSET, 32'h00004000);
	endtask

	task automatic tIrq;
		rdChk("status", IRQ_STAT_OFFSET, 32'h7);
		check("irq", {31'h0, irq}, 32'h0);
		wr(IRQ_EN_OFFSET, 32'h4);
		rdChk("irqEn", IRQ_EN_OFFSET, 32'h4);
		check("irq", {31'h0, irq}, 32'h1);
		wr(IRQ_CLR_OFFSET, 32'h4);
		rdChk("status", IRQ_STAT_OFFSET, 32'h3);
		check("irq", {31'h0, irq}, 32'h0);
		wr(8'h10, 32'hFFFFFFFF);
		rdChk("unmapped", 8'h10, 32'h0);
	endtask

	task automatic tSwap;
		unlock();
		wr(CTRL_OFFSET, 32'h00004080);
		rdChk("ctrl", CTRL_OFFSET, 32'h00004000);
		wr(CTRL_OFFSET, 32'h00000000);
		unlock();
		wr(CTRL_OFFSET, 32'h00000080);
		rdChk("ctrl", CTRL_OFFSET, 32'h00000080);
		check("lowerBank2", {31'h0, lowerBank2}, 32'h1);
		check("bankSwap", {31'h0, bankSwap}, 32'h1);
		wr(CTRL_OFFSET, 32'h00000000);
		rdChk("ctrl", CTRL_OFFSET, 32'h00000080);
	endtask

	task automatic tSysRst;
		wr(CTRL_OFFSET, 32'h00004085);
		sysRst_n <= 1'b0;
		lowVoltPin <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sysRst_n <= 1'b1;
		lowVoltPin <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rdChk("ctrl", CTRL_OFFSET, 32'h00005000);
		check("lowerBank2", {31'h0, lowerBank2}, 32'h0);
	endtask

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		bad_count++;
		final_report();
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdChk("ctrl", CTRL_OFFSET, 32'h0);
		tArmLaunch();
		tLowVolt();
		tIrq();
		tSwap();
		tSysRst();
		final_report();
	end
endmodule // flash_program_control_tb
